// File: logic/tliw_top.sv
// top-level interrupt gathering, watchdog control and parallel ports
`timescale 1ns/1ps
`include "tliw_defines.svh"
// Contract
// [R1] status word bit order, bit 0 zero
// [R2] watchdog expiry sets flag, pulses reset out
// [R3] arbiter timeout event sets arbiter flag
// [R4] other flags summarise local status registers
// [R5] status read clears watchdog and arbiter flags
// [R6] mask bits 6..1, 0 enables, reset enabled
// [R7] masked arbiter flag hidden but kept
// [R8] watchdog flag never masked
// [R9] masked summary flags shown, no interrupt
// [R10] mask write briefly drops active interrupt
// [R11] input port sampled at read strobe fall
// [R12] input port only in multiplexed mode
// [R13] nibble data driven from write strobe fall
// [R14] nibble read samples inputs, upper ones
// [R15] direction 1 output, upper ones, reset inputs
// [R16] watchdog control layout, low bits ones
// [R17] address doubled in multiplexed mode
// [R18] start bit sticky until device reset
// [R19] host services watchdog each 1024 frames
// [R20] host spaces service writes two clocks
// [R21] interrupt while unmasked flag or watchdog
module tliw_top import tliw_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // processor bus pins
  input  wire logic       ale,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n,
  // sub-unit summaries and arbiter event
  input  wire logic       sw_unit_irq,
  input  wire logic       ctrl_a_irq,
  input  wire logic       ctrl_a_ext_irq,
  input  wire logic       ctrl_b_irq,
  input  wire logic       ctrl_b_ext_irq,
  input  wire logic       arbiter_expire,
  // frame timing
  input  wire logic       frame_sync_pin,
  // interrupt and reset outputs
  output logic            int_n,
  output logic            reset_output_pin,
  // parallel ports
  input  wire logic [7:0] input_port_pin,
  input  wire logic [3:0] nib_pin_in,
  output logic      [3:0] nib_pin_out,
  output logic      [3:0] nib_pin_oe_n
);
  localparam int GAP_CYC = `TLIW_INT_GAP_CYC;
  tliw_wd_if wd ();

  logic [31:0]        sync1, sync2;
  logic               ale_s, cs_s_n, rd_s_n, wr_s_n;
  logic [7:0]         addr_s, data_s, in_s;
  logic [3:0]         nib_s;
  logic               ale_d, rd_d_n, wr_d_n;
  logic               mux_mode, next_mux_mode;
  logic [7:0]         mux_addr, next_mux_addr;
  logic [7:0]         eff_addr;
  logic               addr_ok, rd_take, wr_take;
  logic               hit_wdog, hit_stat, hit_in, hit_nib, hit_dir, hit_any;
  tliw_bus_state_type bus, next_bus;
  logic [7:0]         rdata, next_data_out;
  logic               next_data_oe_n;
  logic               wd_flag, next_wd_flag;
  logic               arb_pend, next_arb_pend;
  logic [6:1]         mask, next_mask;
  logic [7:0]         status_view;
  logic               irq_any, next_int_n;
  logic [1:0]         gap, next_gap;
  logic [2:0]         watchdog_control, next_wtc;
  logic               start_run, next_start_run;
  logic               svc_write, next_svc_write;
  logic [3:0]         next_nib_out, next_nib_oe_n;

  tliw_watchdog u_watchdog (
    .clk            (clk),
    .resetn         (resetn),
    .frame_sync_pin (frame_sync_pin),
    .wd             (wd)
  );

  // watchdog control travels through the carrier
  assign wd.run        = start_run;
  assign wd.svc_write  = svc_write;
  assign wd.svc_first  = watchdog_control[2];
  assign wd.svc_second = watchdog_control[1];

  // bus, input port and nibble pins pass two flops before use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 32'h70000000; // strobes and select idle high
      sync2 <= 32'h70000000;
    end else begin
      sync1 <= {ale, cs_n, rd_n, wr_n, addr, data_in, input_port_pin, nib_pin_in};
      sync2 <= sync1;
    end
  end
  assign {ale_s, cs_s_n, rd_s_n, wr_s_n, addr_s, data_s, in_s, nib_s} = sync2;

  // strobe edges and address decode
  always_comb begin
    if (mux_mode) begin
      eff_addr = {1'b0, mux_addr[7:1]}; // R17
      addr_ok  = !mux_addr[0];
    end else begin
      eff_addr = addr_s;
      addr_ok  = 1'b1;
    end
    hit_wdog = addr_ok && eff_addr == `TLIW_OFF_WDOG_CTRL;
    hit_stat = addr_ok && eff_addr == `TLIW_OFF_STATUS;
    hit_in   = addr_ok && eff_addr == `TLIW_OFF_IN_PORT;
    hit_nib  = addr_ok && eff_addr == `TLIW_OFF_NIB_DATA;
    hit_dir  = addr_ok && eff_addr == `TLIW_OFF_NIB_DIR;
    hit_any  = hit_wdog | hit_stat | hit_in | hit_nib | hit_dir;
    rd_take  = rd_d_n && !rd_s_n && !cs_s_n && hit_any;
    wr_take  = wr_d_n && !wr_s_n && !cs_s_n && hit_any;
  end

  // status word as software sees it
  always_comb begin
    status_view                 = 8'h00; // R1
    status_view[`TLIW_BIT_WD]   = wd_flag; // R8
    status_view[`TLIW_BIT_ARB]  = arb_pend & ~mask[`TLIW_BIT_ARB]; // R7
    status_view[`TLIW_BIT_SW]   = sw_unit_irq; // R4
    status_view[`TLIW_BIT_CBX]  = ctrl_b_ext_irq;
    status_view[`TLIW_BIT_CB]   = ctrl_b_irq;
    status_view[`TLIW_BIT_CAX]  = ctrl_a_ext_irq;
    status_view[`TLIW_BIT_CA]   = ctrl_a_irq; // R9
    irq_any = wd_flag | (|(status_view[6:1] & ~mask)); // R21
  end

  // read multiplexer
  always_comb begin
    rdata = 8'h00;
    if (hit_wdog)
      rdata = {watchdog_control, 5'(`TLIW_RST_WDOG_CTRL)}; // R16
    else if (hit_stat)
      rdata = status_view;
    else if (hit_in)
      rdata = mux_mode ? in_s : 8'hFF; // R11 R12
    else if (hit_nib)
      rdata = {4'hF, (nib_s & nib_pin_oe_n) | (nib_pin_out & ~nib_pin_oe_n)}; // R14
    else if (hit_dir)
      rdata = {4'hF, ~nib_pin_oe_n}; // R15
  end

  // bus sequencing: drive data while the strobe stays low
  always_comb begin
    next_bus       = bus;
    next_data_out  = data_out;
    next_data_oe_n = data_oe_n;
    next_mux_mode  = mux_mode | ale_s; // R12
    next_mux_addr  = (ale_d && !ale_s) ? data_s : mux_addr;
    unique case (bus)
      TLIW_BUS_IDLE: begin
        if (rd_take) begin
          next_bus       = TLIW_BUS_READ;
          next_data_out  = rdata;
          next_data_oe_n = 1'b0;
        end else if (wr_take) begin
          next_bus = TLIW_BUS_WRITE;
        end
      end
      TLIW_BUS_READ: begin
        if (rd_s_n || cs_s_n) begin
          next_bus       = TLIW_BUS_IDLE;
          next_data_oe_n = 1'b1;
        end
      end
      TLIW_BUS_WRITE: begin
        if (wr_s_n || cs_s_n)
          next_bus = TLIW_BUS_IDLE;
      end
      default: begin
        next_bus       = TLIW_BUS_IDLE;
        next_data_oe_n = 1'b1;
      end
    endcase
  end

  // flags, mask, interrupt output; a set always beats a read clear
  always_comb begin
    next_wd_flag  = (wd_flag & ~(rd_take & hit_stat)) | wd.expired; // R2 R5
    next_arb_pend = (arb_pend & ~(rd_take & hit_stat & ~mask[`TLIW_BIT_ARB]))
                    | arbiter_expire; // R3 R5 R7
    next_mask     = mask;
    next_gap      = (gap != 2'h0) ? gap - 2'h1 : gap;
    if (wr_take && hit_stat) begin
      next_mask = data_s[6:1]; // R6
      if (!int_n)
        next_gap = 2'(GAP_CYC); // R10
    end
    next_int_n = !(irq_any && next_gap == 2'h0); // R21
  end

  // watchdog control and nibble port registers
  always_comb begin
    next_wtc       = watchdog_control;
    next_start_run = start_run;
    next_svc_write = 1'b0;
    next_nib_out   = nib_pin_out;
    next_nib_oe_n  = nib_pin_oe_n;
    if (wr_take && hit_wdog) begin
      next_wtc       = data_s[7:5]; // R16
      next_start_run = start_run | data_s[`TLIW_BIT_START]; // R18
      next_svc_write = 1'b1;
    end
    if (wr_take && hit_nib)
      next_nib_out = data_s[3:0]; // R13
    if (wr_take && hit_dir)
      next_nib_oe_n = ~data_s[3:0]; // R15
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ale_d            <= 1'b0;
      rd_d_n           <= 1'b1;
      wr_d_n           <= 1'b1;
      mux_mode         <= 1'b0;
      mux_addr         <= 8'h00;
      bus              <= TLIW_BUS_IDLE;
      data_out         <= 8'h00;
      data_oe_n        <= 1'b1;
      wd_flag          <= 1'b0;
      arb_pend         <= 1'b0;
      mask             <= 6'h00;
      gap              <= 2'h0;
      int_n            <= 1'b1;
      watchdog_control              <= 3'h0;
      start_run        <= 1'b0;
      svc_write        <= 1'b0;
      nib_pin_out      <= 4'h0;
      nib_pin_oe_n     <= 4'hF;
      reset_output_pin <= 1'b0;
    end else begin
      ale_d            <= ale_s;
      rd_d_n           <= rd_s_n;
      wr_d_n           <= wr_s_n;
      mux_mode         <= next_mux_mode;
      mux_addr         <= next_mux_addr;
      bus              <= next_bus;
      data_out         <= next_data_out;
      data_oe_n        <= next_data_oe_n;
      wd_flag          <= next_wd_flag;
      arb_pend         <= next_arb_pend;
      mask             <= next_mask;
      gap              <= next_gap;
      int_n            <= next_int_n;
      watchdog_control              <= next_wtc;
      start_run        <= next_start_run;
      svc_write        <= next_svc_write;
      nib_pin_out      <= next_nib_out;
      nib_pin_oe_n     <= next_nib_oe_n;
      reset_output_pin <= wd.reset_active; // R2
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_status_layout;
    rd_take && hit_stat |=> data_out[0] == 1'b0 && data_out[7] == $past(wd_flag);
  endproperty
  a_status_layout: assert property (p_status_layout) // R1
    else $error("status word layout wrong");

  property p_expiry;
    wd.expired |=> wd_flag && reset_output_pin;
  endproperty
  a_expiry: assert property (p_expiry) // R2
    else $error("expiry did not raise flag and reset out");

  property p_read_clears;
    rd_take && hit_stat && !wd.expired && !arbiter_expire && !mask[6] |=> !wd_flag && !arb_pend;
  endproperty
  a_read_clears: assert property (p_read_clears) // R5
    else $error("status read did not clear flags");

  property p_arb_hidden;
    rd_take && hit_stat && mask[6] && arb_pend |=> !data_out[6] ##0 arb_pend;
  endproperty
  a_arb_hidden: assert property (p_arb_hidden) // R7
    else $error("masked arbiter flag shown or lost");

  property p_wd_int;
    wd_flag && gap == 2'h0 && !(wr_take && hit_stat && !int_n) |=> !int_n;
  endproperty
  a_wd_int: assert property (p_wd_int) // R8
    else $error("watchdog flag not signalled");

  property p_mask_gap;
    wr_take && hit_stat && !int_n |=> int_n [*2];
  endproperty
  a_mask_gap: assert property (p_mask_gap) // R10
    else $error("mask write gave no inactive gap");

  property p_nib_write;
    wr_take && hit_nib |=> nib_pin_out == $past(data_s[3:0]);
  endproperty
  a_nib_write: assert property (p_nib_write) // R13
    else $error("nibble port did not take written data");

  property p_nib_upper;
    rd_take && (hit_nib || hit_dir) |=> data_out[7:4] == 4'hF && !data_oe_n;
  endproperty
  a_nib_upper: assert property (p_nib_upper) // R14
    else $error("nibble read upper bits not ones");

  property p_start_sticky;
    start_run |=> start_run;
  endproperty
  a_start_sticky: assert property (p_start_sticky) // R18
    else $error("watchdog stopped without reset");

  c_status_read: cover property (rd_take && hit_stat ##1 data_out[7]);
  c_mask_gap: cover property (wr_take && hit_stat && !int_n ##3 !int_n);
  c_expiry: cover property (wd.expired);
  c_nib_out: cover property (wr_take && hit_dir ##[1:20] wr_take && hit_nib);
endmodule

// File: logic/tliw_defines.svh
// offsets, field positions, reset values and timing of the top-level glue
`ifndef TLIW_DEFINES_SVH
`define TLIW_DEFINES_SVH
`define TLIW_OFF_WDOG_CTRL  8'h40
`define TLIW_OFF_STATUS     8'h41
`define TLIW_OFF_IN_PORT    8'h42
`define TLIW_OFF_NIB_DATA   8'h43
`define TLIW_OFF_NIB_DIR    8'h44
`define TLIW_BIT_WD         7
`define TLIW_BIT_ARB        6
`define TLIW_BIT_SW         5
`define TLIW_BIT_CBX        4
`define TLIW_BIT_CB         3
`define TLIW_BIT_CAX        2
`define TLIW_BIT_CA         1
`define TLIW_BIT_SVC_FIRST  7
`define TLIW_BIT_SVC_SECOND 6
`define TLIW_BIT_START      5
`define TLIW_RST_WDOG_CTRL  8'h1F
`define TLIW_RST_MASK       8'h00
`define TLIW_RST_NIB_DIR    8'hF0
`define TLIW_MASK_WRITABLE  8'h7E
`define TLIW_CLK_PERIOD_PS  8000
`define TLIW_WD_FRAMES      1024
`define TLIW_RESET_OUT_NS   1000
`define TLIW_RESET_OUT_CYC  ((`TLIW_RESET_OUT_NS * 1000 + `TLIW_CLK_PERIOD_PS - 1) / `TLIW_CLK_PERIOD_PS)
`define TLIW_INT_GAP_NS     16
`define TLIW_INT_GAP_CYC    ((`TLIW_INT_GAP_NS * 1000 + `TLIW_CLK_PERIOD_PS - 1) / `TLIW_CLK_PERIOD_PS)
`endif

// File: logic/tliw_pkg.sv
// types of the top-level glue
package tliw_pkg;
  typedef enum logic [1:0] {
    TLIW_SVC_IDLE  = 2'b01,
    TLIW_SVC_ARMED = 2'b10
  } tliw_svc_state_type;
  typedef enum logic [2:0] {
    TLIW_BUS_IDLE  = 3'b001,
    TLIW_BUS_READ  = 3'b010,
    TLIW_BUS_WRITE = 3'b100
  } tliw_bus_state_type;
endpackage

// File: logic/tliw_wd_if.sv
// carrier between register logic and watchdog
`timescale 1ns/1ps
interface tliw_wd_if;
  logic run;
  logic svc_write;
  logic svc_first;
  logic svc_second;
  logic expired;
  logic reset_active;
  modport ctrl (output run, output svc_write, output svc_first, output svc_second,
                input expired, input reset_active);
  modport wd (input run, input svc_write, input svc_first, input svc_second,
              output expired, output reset_active);
endinterface

// File: logic/tliw_watchdog.sv
// watchdog counting frame syncs, service sequence and reset pulse
`timescale 1ns/1ps
`include "tliw_defines.svh"
module tliw_watchdog import tliw_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // frame sync pin
  input wire logic frame_sync_pin,
  // register side
  tliw_wd_if.wd    wd
);
  localparam int RST_CYC = `TLIW_RESET_OUT_CYC;
  logic [2:0]         fs_sync;
  tliw_svc_state_type state, next_state;
  logic [9:0]         frames, next_frames;
  logic [7:0]         rst_cnt, next_rst_cnt;
  logic               next_expired;
  logic               fs_rise;

  // second and third stage only feed the edge detector
  assign fs_rise = fs_sync[1] & ~fs_sync[2];

  // service sequence, frame counting and expiry
  always_comb begin
    next_state   = state;
    next_frames  = frames;
    next_rst_cnt = (rst_cnt != 8'h00) ? rst_cnt - 8'h01 : rst_cnt;
    next_expired = 1'b0;
    if (wd.run && fs_rise) begin
      if (frames == 10'(`TLIW_WD_FRAMES - 1)) begin
        next_frames  = 10'h000;
        next_expired = 1'b1; // R2
        next_rst_cnt = 8'(RST_CYC);
      end else begin
        next_frames = frames + 10'h001;
      end
    end
    // a good service in the same cycle as the last sync still saves the run
    if (wd.svc_write) begin
      unique case (state)
        TLIW_SVC_IDLE: begin
          if (wd.svc_first && !wd.svc_second)
            next_state = TLIW_SVC_ARMED; // R19
        end
        TLIW_SVC_ARMED: begin
          next_state = TLIW_SVC_IDLE;
          if (!wd.svc_first && wd.svc_second) begin
            next_frames  = 10'h000; // R19
            next_expired = 1'b0;
            next_rst_cnt = (rst_cnt != 8'h00) ? rst_cnt - 8'h01 : rst_cnt;
          end
        end
        default: next_state = TLIW_SVC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fs_sync         <= 3'h0;
      state           <= TLIW_SVC_IDLE;
      frames          <= 10'h000;
      rst_cnt         <= 8'h00;
      wd.expired      <= 1'b0;
      wd.reset_active <= 1'b0;
    end else begin
      fs_sync         <= {fs_sync[1:0], frame_sync_pin};
      state           <= next_state;
      frames          <= next_frames;
      rst_cnt         <= next_rst_cnt;
      wd.expired      <= next_expired;
      wd.reset_active <= next_rst_cnt != 8'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_service_clears;
    wd.svc_write && state == TLIW_SVC_ARMED && !wd.svc_first && wd.svc_second
      |=> frames == 10'h000 && !wd.expired;
  endproperty
  a_service_clears: assert property (p_service_clears) // R19
    else $error("service sequence did not restart the count");

  property p_idle_no_count;
    !wd.run |=> frames == $past(frames) && !wd.expired;
  endproperty
  a_idle_no_count: assert property (p_idle_no_count) // R18
    else $error("watchdog counted while not started");
endmodule

// File: verification/tliw_host.sv
// processor bus model driving the device pins in both bus modes
`timescale 1ns/1ps
module tliw_host (
  // clock
  input  wire logic       clk,
  // bus pins toward the device
  output logic            ale,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] addr,
  output logic      [7:0] data_in,
  // read data from the device
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n
);
  logic mux;

  // idle bus, demultiplexed until told otherwise
  initial begin
    {mux, ale, cs_n, rd_n, wr_n} = 5'b00111;
    addr    = 8'h00;
    data_in = 8'h00;
  end

  // address phase, then setup clocks before the strobe falls
  task automatic setup(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cs_n    = 1'b0;
    addr    = mux ? ~a : a; // unused in mux mode, so never a helpful copy
    data_in = a;
    ale     = mux;
    repeat (2) @(negedge clk);
    ale     = 1'b0;
    // address stays one clock past the latch-enable fall
    @(negedge clk);
    data_in = d;
    repeat (3) @(negedge clk);
  endtask

  // no ready pin: strobe held six clocks, answer is due after four
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    setup(a, d);
    wr_n = 1'b0;
    repeat (6) @(negedge clk);
    wr_n    = 1'b1;
    cs_n    = 1'b1;
    data_in = ~d; // released bus must not keep showing the byte
    repeat (6) @(negedge clk);
  endtask

  // read sampled while the strobe is still low
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oe_n);
    setup(a, ~a);
    rd_n = 1'b0;
    repeat (6) @(posedge clk);
    d    = data_out;
    oe_n = data_oe_n;
    @(negedge clk);
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
endmodule

// File: verification/top_level_irq_watchdog_ports_tb.sv
// self-checking bench for the top-level interrupt, watchdog and port glue
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module top_level_irq_watchdog_ports_tb;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       ale, cs_n, rd_n, wr_n, data_oe_n, int_n, reset_output_pin;
  logic       arbiter_expire, frame_sync_pin, oe_v, fs_en, int_hi_seen;
  logic [7:0] addr, data_in, data_out, input_port_pin, rd_v;
  logic [4:0] irq;
  logic [3:0] nib_pin_in, nib_pin_out, nib_pin_oe_n, nib_ext;
  integer     n_errors, checks, seed, cycles, frames, fs_div, rst_cnt, i;
  integer     m_mask, m_dir, m_nib, m_irq, act;

  always #4 clk = ~clk;
  // pin level: device drive wins where enabled, outside level elsewhere
  assign nib_pin_in = (~nib_pin_oe_n & nib_pin_out) | (nib_pin_oe_n & nib_ext);

  tliw_top i_tliw_top (
    .clk(clk), .resetn(resetn), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .sw_unit_irq(irq[4]), .ctrl_b_ext_irq(irq[3]), .ctrl_b_irq(irq[2]),
    .ctrl_a_ext_irq(irq[1]), .ctrl_a_irq(irq[0]), .arbiter_expire(arbiter_expire),
    .frame_sync_pin(frame_sync_pin), .int_n(int_n), .reset_output_pin(reset_output_pin),
    .input_port_pin(input_port_pin), .nib_pin_in(nib_pin_in), .nib_pin_out(nib_pin_out),
    .nib_pin_oe_n(nib_pin_oe_n));

  tliw_host i_tliw_host (
    .clk(clk), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  // cycle ceiling, reset-out width and interrupt release watch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (reset_output_pin === 1'b1) rst_cnt <= rst_cnt + 1;
    if (int_n === 1'b1) int_hi_seen <= 1'b1;
    if (cycles == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // frame sync: one rising edge every eight clocks while enabled
  always @(negedge clk) if (fs_en) begin
    fs_div = (fs_div + 1) % 8;
    frame_sync_pin = (fs_div < 2);
    if (fs_div == 0) frames++;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_tliw_host.rd(a, rd_v, oe_v);
    `CHK(oe_v, 1'b0)
    `CHK(rd_v, e)
  endtask

  task automatic pulse_arb();
    @(negedge clk);
    arbiter_expire = 1'b1;
    @(negedge clk);
    arbiter_expire = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic wait_frames(input integer n);
    integer t;
    t = frames + n;
    while (frames < t) @(posedge clk);
  endtask

  initial begin
    n_errors = 0;
    checks = 0;
    cycles = 0;
    frames = 0;
    fs_div = 0;
    rst_cnt = 0;
    seed = 32'hc261;
    irq = 5'h00;
    arbiter_expire = 1'b0;
    frame_sync_pin = 1'b0;
    fs_en = 1'b0;
    int_hi_seen = 1'b0;
    input_port_pin = 8'h00;
    nib_ext = 4'hA;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(int_n, 1'b1)
    `CHK(nib_pin_oe_n, 4'hF)
    rd_chk(8'h40, 8'h1F);
    rd_chk(8'h44, 8'hF0);
    rd_chk(8'h43, 8'hFA);
    rd_chk(8'h41, 8'h00);
    rd_chk(8'h42, 8'hFF);
    i_tliw_host.rd(8'h45, rd_v, oe_v);
    `CHK(oe_v, 1'b1)
    // nibble port: random directions, latch and outside levels
    for (i = 0; i < 4; i++) begin
      m_dir = $random(seed) & 15;
      m_nib = $random(seed) & 15;
      nib_ext = $random(seed);
      i_tliw_host.wr(8'h44, 8'(m_dir));
      i_tliw_host.wr(8'h43, 8'(m_nib));
      `CHK(nib_pin_oe_n, 4'(~m_dir))
      `CHK(nib_pin_out & 4'(m_dir), 4'(m_nib & m_dir))
      rd_chk(8'h44, 8'(8'hF0 | m_dir));
      rd_chk(8'h43, 8'(8'hF0 | (m_dir & m_nib) | (~m_dir & nib_ext)));
    end
    // summary flags against random masks; each write drops an active line
    m_mask = 0;
    for (i = 0; i < 12; i++) begin
      m_irq = $random(seed) & 31;
      irq = 5'(m_irq);
      act = (m_irq & ~(m_mask >> 1)) != 0;
      repeat (4) @(negedge clk);
      int_hi_seen = 1'b0;
      m_mask = $random(seed) & 8'h3E;
      i_tliw_host.wr(8'h41, 8'(m_mask));
      if (act) `CHK(int_hi_seen, 1'b1)
      `CHK(int_n, ((m_irq & ~(m_mask >> 1) & 31) != 0) ? 1'b0 : 1'b1)
      rd_chk(8'h41, 8'(m_irq << 1));
    end
    // arbiter event: cleared by status read, hidden while masked
    irq = 5'h00;
    i_tliw_host.wr(8'h41, 8'h00);
    pulse_arb();
    `CHK(int_n, 1'b0)
    rd_chk(8'h41, 8'h40);
    rd_chk(8'h41, 8'h00);
    `CHK(int_n, 1'b1)
    i_tliw_host.wr(8'h41, 8'h40);
    pulse_arb();
    `CHK(int_n, 1'b1)
    rd_chk(8'h41, 8'h00);
    i_tliw_host.wr(8'h41, 8'h00);
    rd_chk(8'h41, 8'h40);
    // watchdog: start, one service, then let it expire with all masked
    i_tliw_host.wr(8'h40, 8'h20);
    rd_chk(8'h40, 8'h3F);
    i_tliw_host.wr(8'h41, 8'h7E);
    fs_en = 1'b1;
    wait_frames(600);
    i_tliw_host.wr(8'h40, 8'hA0);
    i_tliw_host.wr(8'h40, 8'h60);
    rd_chk(8'h40, 8'h7F);
    wait_frames(1000);
    `CHK(rst_cnt, 0)
    wait_frames(40);
    repeat (200) @(negedge clk);
    `CHK(rst_cnt, 125)
    `CHK(int_n, 1'b0)
    rd_chk(8'h41, 8'h80);
    rd_chk(8'h41, 8'h00);
    // multiplexed mode: doubled addresses and the input port
    fs_en = 1'b0;
    i_tliw_host.mux = 1'b1;
    input_port_pin = $random(seed);
    rd_chk(8'h84, input_port_pin);
    rd_chk(8'h80, 8'h7F);
    i_tliw_host.rd(8'h85, rd_v, oe_v);
    `CHK(oe_v, 1'b1)
    tally_and_finish();
  end
endmodule
